// ==== hw/crs_core_regs.v ====
`timescale 1ns/1ps
`include "crs_map.vh"
// ----------------------------------------
// Core register set
// ----------------------------------------
// Registers live outside the software register space; only the execution
// unit drives the write ports below.
module crs_core_regs (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Program counter control
  input wire pc_inc,
  input wire pc_load,
  input wire [15:0] pc_load_val,
  // Accumulator write
  input wire acc_we,
  input wire [7:0] acc_wdata,
  // Index write
  input wire idx_we,
  input wire [7:0] idx_wdata,
  // Stack pointer control
  input wire [1:0] sp_op,
  input wire [7:0] sp_wdata,
  // Flag updates
  input wire alu_upd_zero,
  input wire alu_upd_carry,
  input wire alu_zero,
  input wire alu_carry,
  input wire flag_op_en,
  input wire [1:0] flag_op,
  input wire [7:0] flag_op_imm,
  input wire super_set_en,
  input wire super_val,
  // Addressing helpers
  input wire [7:0] index_operand,
  output wire [7:0] indexed_addr,
  // Register contents
  output wire [15:0] program_counter,
  output wire [7:0] accumulator,
  output wire [7:0] index_reg,
  output wire [7:0] stack_pointer,
  output wire [7:0] core_flags,
  output wire global_irq_enable,
  output wire reg_bank_select,
  output wire super_mode
);

  reg [15:0] pc_q;
  reg [15:0] pc_d;
  wire pc_wr;

  reg [7:0] acc_q;
  reg [7:0] acc_d;
  reg [7:0] idx_q;
  reg [7:0] idx_d;
  wire [7:0] idx_sum;

  reg [7:0] sp_q;
  reg [7:0] sp_d;
  wire sp_wr;

  reg [7:0] flags_q;
  wire [7:0] flags_d;
  wire flags_wr;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Eight-bit sum that wraps, shared by the stack steps and indexed addressing
  function [7:0] add8;
    input [7:0] a;
    input [7:0] b;
    begin
      add8 = a + b;
    end
  endfunction

  // Byte write port shared by the accumulator and the index register
  function [7:0] pick8;
    input we;
    input [7:0] new_val;
    input [7:0] old_val;
    begin
      if (we)
      begin
        pick8 = new_val;
      end
      else
      begin
        pick8 = old_val;
      end
    end
  endfunction

  // Load wins over increment, so a jump never also steps
  function [15:0] pc_step;
    input [15:0] cur;
    input inc;
    input load;
    input [15:0] target;
    begin
      if (load)
      begin
        pc_step = target;
      end
      else if (inc)
      begin
        pc_step = cur + 16'h0001;
      end
      else
      begin
        pc_step = cur;
      end
    end
  endfunction

  // Steps wrap modulo 256; nothing detects overflow, software bounds the stack
  function [7:0] sp_step;
    input [7:0] cur;
    input [1:0] op;
    input [7:0] wdata;
    begin
      case (op)
        `CRS_SP_HOLD:
        begin
          sp_step = cur;
        end
        `CRS_SP_INC:
        begin
          sp_step = add8(cur, 8'h01);
        end
        `CRS_SP_DEC:
        begin
          sp_step = add8(cur, 8'hFF);
        end
        `CRS_SP_LOAD:
        begin
          sp_step = wdata;
        end
        default:
        begin
          sp_step = cur;
        end
      endcase
    end
  endfunction

  // One flag bit picked out by its position
  function flag_bit;
    input [7:0] flags;
    input integer pos;
    begin
      flag_bit = flags[pos];
    end
  endfunction

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  // Full 16-bit wrap, one flat space, so no bank register exists here
  // Holding without a strobe keeps the counter still while the core stalls
  assign pc_wr = pc_load | pc_inc;

  always @*
  begin
    pc_d = pc_step(pc_q, pc_inc, pc_load, pc_load_val);
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc_q <= `CRS_PC_RST;
    end
    else if (pc_wr)
    begin
      pc_q <= pc_d;
    end
  end

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  // Takes every source-mode result; nothing in the register space decodes it
  // Only the execution unit raises the strobe
  always @*
  begin
    acc_d = pick8(acc_we, acc_wdata, acc_q);
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_q <= `CRS_ACC_RST;
    end
    else
    begin
      acc_q <= acc_d;
    end
  end

  // ----------------------------------------
  // Index register
  // ----------------------------------------
  // Loaded only by instructions, like the accumulator
  always @*
  begin
    idx_d = pick8(idx_we, idx_wdata, idx_q);
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      idx_q <= `CRS_IDX_RST;
    end
    else
    begin
      idx_q <= idx_d;
    end
  end

  // Offset for indexed modes; the sum wraps within the byte
  assign idx_sum = add8(index_operand, idx_q);

  // ----------------------------------------
  // Stack pointer
  // ----------------------------------------
  // Load takes sp_wdata as it stands, for the swap and add cases
  assign sp_wr = (sp_op != `CRS_SP_HOLD);

  always @*
  begin
    sp_d = sp_step(sp_q, sp_op, sp_wdata);
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sp_q <= `CRS_SP_RST;
    end
    else if (sp_wr)
    begin
      sp_q <= sp_d;
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  // Zero flag resets set, the other bits clear
  // Any of the four sources may move the register; in a flag-operation cycle the ALU updates are dropped
  assign flags_wr = flag_op_en | alu_upd_zero | alu_upd_carry | super_set_en;

  crs_flag_logic u_flags (
    .flags_cur(flags_q),
    .alu_upd_zero(alu_upd_zero),
    .alu_upd_carry(alu_upd_carry),
    .alu_zero(alu_zero),
    .alu_carry(alu_carry),
    .flag_op_en(flag_op_en),
    .flag_op(flag_op),
    .flag_op_imm(flag_op_imm),
    .super_set_en(super_set_en),
    .super_val(super_val),
    .flags_next(flags_d)
  );

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flags_q <= `CRS_FLAGS_RST;
    end
    else if (flags_wr)
    begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------
  // Register contents
  // ----------------------------------------
  assign indexed_addr = idx_sum;
  assign program_counter = pc_q;
  assign accumulator = acc_q;
  assign index_reg = idx_q;
  assign stack_pointer = sp_q;

  // ----------------------------------------
  // Flag views
  // ----------------------------------------
  // Direct taps, so they never run ahead of the flag register
  assign core_flags = flags_q;
  assign global_irq_enable = flag_bit(flags_q, `CRS_FLAG_GIE);
  assign reg_bank_select = flag_bit(flags_q, `CRS_FLAG_BANK);
  assign super_mode = flag_bit(flags_q, `CRS_FLAG_SUPER);
endmodule

// ==== common/crs_map.vh ====
`ifndef CRS_MAP_VH
`define CRS_MAP_VH
`define CRS_FLAG_GIE 0
`define CRS_FLAG_ZERO 1
`define CRS_FLAG_CARRY 2
`define CRS_FLAG_SUPER 3
`define CRS_FLAG_BANK 4
`define CRS_FLAG_RSVD_MASK 8'hE0
`define CRS_FLAGS_RST 8'h02
`define CRS_ACC_RST 8'h00
`define CRS_IDX_RST 8'h00
`define CRS_SP_RST 8'h00
`define CRS_PC_RST 16'h0000
`define CRS_FOP_AND 2'h0
`define CRS_FOP_OR 2'h1
`define CRS_FOP_XOR 2'h2
`define CRS_SP_HOLD 2'h0
`define CRS_SP_INC 2'h1
`define CRS_SP_DEC 2'h2
`define CRS_SP_LOAD 2'h3
`endif

// ==== hw/crs_flag_logic.v ====
`timescale 1ns/1ps
`include "crs_map.vh"
module crs_flag_logic (
  // Current flags and ALU status
  input wire [7:0] flags_cur,
  input wire alu_upd_zero,
  input wire alu_upd_carry,
  input wire alu_zero,
  input wire alu_carry,
  // Logical operation on the flags
  input wire flag_op_en,
  input wire [1:0] flag_op,
  input wire [7:0] flag_op_imm,
  // Supervisor mode control
  input wire super_set_en,
  input wire super_val,
  // Result
  output reg [7:0] flags_next
);
  reg [7:0] f;
  always @*
  begin
    f = flags_cur;
    if (flag_op_en)
    begin
      case (flag_op)
        `CRS_FOP_AND: f = flags_cur & flag_op_imm;
        `CRS_FOP_OR: f = flags_cur | flag_op_imm;
        `CRS_FOP_XOR: f = flags_cur ^ flag_op_imm;
        default: f = flags_cur;
      endcase
      // Supervisory bit is read-only to user code
      f[`CRS_FLAG_SUPER] = flags_cur[`CRS_FLAG_SUPER];
    end
    else
    begin
      if (alu_upd_zero)
        f[`CRS_FLAG_ZERO] = alu_zero;
      if (alu_upd_carry)
        f[`CRS_FLAG_CARRY] = alu_carry;
    end
    if (super_set_en)
      f[`CRS_FLAG_SUPER] = super_val;
    flags_next = f & ~`CRS_FLAG_RSVD_MASK;
  end
endmodule

// ==== testbench/crs_chk_checker.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Register set checks
// ----------------------------------------
module crs_chk (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Controls
  input wire pc_load,
  input wire [15:0] pc_load_val,
  input wire acc_we,
  input wire [7:0] acc_wdata,
  input wire [1:0] sp_op,
  input wire super_set_en,
  input wire super_val,
  input wire [7:0] index_operand,
  // Contents
  input wire [7:0] indexed_addr,
  input wire [15:0] program_counter,
  input wire [7:0] accumulator,
  input wire [7:0] index_reg,
  input wire [7:0] stack_pointer,
  input wire [7:0] core_flags,
  input wire global_irq_enable,
  input wire reg_bank_select,
  input wire super_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  acc_write_a: assert property (acc_we |=> accumulator == $past(acc_wdata))
    else $error("acc write lost");
  pc_load_a: assert property (pc_load |=> program_counter == $past(pc_load_val))
    else $error("pc load lost");
  sp_down_a: assert property (sp_op == 2'h2
    |=> stack_pointer == $past(stack_pointer) - 8'h1)
    else $error("sp dec wrong");
  sp_up_a: assert property (sp_op == 2'h1
    |=> stack_pointer == $past(stack_pointer) + 8'h1)
    else $error("sp inc wrong");
  rsvd_zero_a: assert property (core_flags[7:5] == 3'h0)
    else $error("reserved set");
  flag_alias_a: assert property ({global_irq_enable, reg_bank_select, super_mode}
    == {core_flags[0], core_flags[4], core_flags[3]})
    else $error("flag alias");
  super_keep_a: assert property (!super_set_en |=> $stable(super_mode))
    else $error("super moved");
  super_set_a: assert property (super_set_en |=> super_mode == $past(super_val))
    else $error("super set");
  index_add_a: assert property (indexed_addr == index_operand + index_reg)
    else $error("index sum");
endmodule
bind crs_core_regs crs_chk chk_u (.*);

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Random run against a bench model
// ----------------------------------------
module tb_top;
  reg sys_clk = 1'b0;
  reg rstn = 1'b0;
  reg [95:0] s = 96'h0;
  reg [31:0] r = 32'h0DCAC2AA;
  reg [15:0] pc = 16'h0;
  reg [7:0] a = 8'h0, x = 8'h0, sp = 8'h0, f = 8'h02;
  integer failures = 0, checks = 0, i;
  wire [15:0] pc_o;
  wire [7:0] a_o, x_o, sp_o, f_o, ia_o;
  wire ie_o, bk_o, su_o;
  crs_core_regs dut_u (.sys_clk(sys_clk), .rstn(rstn), .pc_inc(s[0]), .pc_load(s[1]),
    .pc_load_val(s[31:16]), .acc_we(s[2]), .acc_wdata(s[39:32]), .idx_we(s[3]),
    .idx_wdata(s[47:40]), .sp_op(s[12:11]), .sp_wdata(s[55:48]), .alu_upd_zero(s[4]),
    .alu_upd_carry(s[5]), .alu_zero(s[6]), .alu_carry(s[7]), .flag_op_en(s[8]),
    .flag_op(s[14:13]), .flag_op_imm(s[63:56]), .super_set_en(s[9]), .super_val(s[10]),
    .index_operand(s[71:64]), .indexed_addr(ia_o), .program_counter(pc_o),
    .accumulator(a_o), .index_reg(x_o), .stack_pointer(sp_o), .core_flags(f_o),
    .global_irq_enable(ie_o), .reg_bank_select(bk_o), .super_mode(su_o));
  function [31:0] xs;
    begin
      r = r ^ (r << 13);
      r = r ^ (r >> 17);
      r = r ^ (r << 5);
      xs = r;
    end
  endfunction
  // Supervisor entry or exit overrides whatever the same cycle does to the super bit
  function [7:0] nf(input [7:0] v);
    begin
      nf = v;
      if (s[8])
      begin
        case (s[14:13])
          2'h0: nf = v & s[63:56];
          2'h1: nf = v | s[63:56];
          2'h2: nf = v ^ s[63:56];
          default: nf = v;
        endcase
        nf = {3'h0, nf[4], v[3], nf[2:0]};
      end
      else
      begin
        if (s[4]) nf[1] = s[6];
        if (s[5]) nf[2] = s[7];
      end
      if (s[9]) nf[3] = s[10];
    end
  endfunction
  task ck(input [15:0] g, input [15:0] e);
    begin
      checks = checks + 1;
      if (g !== e)
      begin
        failures = failures + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial forever #10 sys_clk = ~sys_clk;
  initial
  begin
    #200000;
    failures = failures + 1;
    give_verdict;
  end
  initial
  begin
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    for (i = 0; i < 600; i = i + 1)
    begin
      @(negedge sys_clk);
      ck(pc_o, pc);
      ck(a_o, a);
      ck(x_o, x);
      ck(ia_o, {8'h0, s[71:64] + x});
      ck(sp_o, sp);
      ck(f_o, f);
      ck({ie_o, bk_o, su_o}, {f[0], f[4], f[3]});
      s = {xs(), xs(), xs()};
      // First step: sp wraps below zero and OR sets every writable flag
      if (i == 0) {s[63:56], s[14:8]} = {8'hFF, 7'h31};
      // Second step: supervisor entry meets an XOR that tries to flip the super bit
      if (i == 1) {s[14:13], s[10:8], s[63:56]} = {2'h2, 3'h7, 8'h08};
      rstn = (i != 300);
      if (!rstn) {pc, a, x, sp, f} = 48'h2;
      else
      begin
        f = nf(f);
        pc = s[1] ? s[31:16] : pc + s[0];
        a = s[2] ? s[39:32] : a;
        x = s[3] ? s[47:40] : x;
        if (s[12:11] == 2'h3) sp = s[55:48];
        else sp = sp + s[11] - s[12];
      end
    end
    $display("random test done");
    give_verdict;
  end
endmodule
